/* File: verilog/dpb_dual_port_ram.sv */
// module: two-port synchronous memory with burst counters and selectable output latency
`default_nettype none
`timescale 1ns/100ps
module dpb_dual_port_ram
    import dpb_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // left port inputs
    input  wire dpb_pin_t          leftPins,
    input  wire logic [LANES-1:0]  byteLaneSelectsN,
    // left port outputs
    output logic      [WORD_W-1:0] leftDataOut,
    output logic      [LANES-1:0]  leftDataOe,
    output logic                   leftPowerDown,
    // right port inputs
    input  wire dpb_pin_t          rightPins,
    input  wire logic              widthMatchSelect,
    input  wire logic              narrowSize,
    input  wire logic              bigEndianSelect,
    // right port outputs
    output logic      [WORD_W-1:0] rightDataOut,
    output logic      [LANES-1:0]  rightDataOe,
    output logic                   rightPowerDown
);

    // whole state: array plus both ports
    dpb_top_st_t st_r;
    dpb_top_st_t st_nxt;

    // per-port decode shared between the port slices and the update process
    dpb_pin_t          pins     [PORTS];
    logic [ADDR_W-1:0] cntVal   [PORTS];
    logic [ADDR_W-1:0] accAddr  [PORTS];
    dpb_width_t        width    [PORTS];
    logic [1:0]        pieceUse [PORTS];
    logic [1:0]        pieceEnd [PORTS];
    logic [1:0]        laneIdx  [PORTS];

    assign pins[PORT_LEFT]  = leftPins;
    assign pins[PORT_RIGHT] = rightPins;

    // one slice per port: counter and piece bookkeeping, each fully independent
    for (genvar p = 0; p < PORTS; p++) begin : gPort
        logic stepEn;
        logic narrowPort;

        // only the right port has the narrow widths
        assign narrowPort = (p == PORT_RIGHT) && widthMatchSelect;

        always_comb begin
            if (!narrowPort) begin
                width[p]    = WID_FULL;
                pieceEnd[p] = PIECE_FIRST;
            end else if (narrowSize) begin
                width[p]    = WID_X9;
                pieceEnd[p] = PIECE_LAST_X9;
            end else begin
                width[p]    = WID_X18;
                pieceEnd[p] = PIECE_LAST_X18;
            end
        end

        // a new address or a clear restarts the word at its first piece
        assign pieceUse[p] = (!pins[p].addrStrobeN || !pins[p].counterClearN)
                             ? PIECE_FIRST : st_r.port[p].piece;

        // the counter only moves on to the next word once all pieces are done
        assign stepEn = (st_r.port[p].piece == PIECE_FIRST);

        // big endian sends the most significant piece first
        assign laneIdx[p] = ((p == PORT_RIGHT) && bigEndianSelect)
                            ? pieceEnd[p] - pieceUse[p] : pieceUse[p];

        // own counter in this port's address path
        dpb_burst_ctr uCtr (
            .ref_clk       (ref_clk),
            .rst_n         (rst_n),
            .extAddr       (pins[p].addr),
            .addrStrobeN   (pins[p].addrStrobeN),
            .countAdvanceN (pins[p].countAdvanceN),
            .counterClearN (pins[p].counterClearN),
            .stepEn        (stepEn),
            .cntVal        (cntVal[p]),
            .accAddr       (accAddr[p])
        );
    end

    // array update and read path of both ports
    always_comb begin
        dpb_pin_t          pin;
        dpb_rd_t           rdNow;
        dpb_rd_t           rdSrc;
        logic [WORD_W-1:0] rdWord;
        logic [WORD_W-1:0] wrWord;
        logic [LANES-1:0]  mask;
        logic              access;
        pin    = '0;
        rdNow  = '0;
        rdSrc  = '0;
        rdWord = '0;
        wrWord = '0;
        mask   = LANES_NONE;
        access = 1'b0;
        st_nxt = st_r;
        for (int p = 0; p < PORTS; p++) begin
            pin = pins[p];
            // a powered-down port and a counter read-back touch no word
            access = !pin.chipEnableN && !pin.counterReadback;
            // reads see the array as it stood before this edge's writes
            rdWord = st_r.mem[accAddr[p]];

            // lanes touched and data spread over them for this width
            case (width[p])
                WID_X9: begin
                    mask   = LANES_ONE << laneIdx[p];
                    wrWord = {LANES{pin.dataIn[LANE_W-1:0]}};
                end
                WID_X18: begin
                    mask   = laneIdx[p][0] ? LANES_HI_HALF : LANES_LO_HALF;
                    wrWord = {2{pin.dataIn[2*LANE_W-1:0]}};
                end
                default: begin
                    mask   = (p == PORT_LEFT) ? ~byteLaneSelectsN : LANES_ALL;
                    wrWord = pin.dataIn;
                end
            endcase

            // write: one internal pulse per sampled write cycle
            if (access && !pin.readWriteN) begin
                for (int l = 0; l < LANES; l++) begin
                    if (mask[l]) begin
                        st_nxt.mem[accAddr[p]][l*LANE_W +: LANE_W] = wrWord[l*LANE_W +: LANE_W];
                    end
                end
            end

            // read result of this cycle, narrow pieces land on the low lines
            rdNow.valid = access && pin.readWriteN;
            case (width[p])
                WID_X9: begin
                    rdNow.data  = WORD_W'(rdWord[laneIdx[p]*LANE_W +: LANE_W]);
                    rdNow.lanes = LANES_ONE;
                end
                WID_X18: begin
                    rdNow.data  = laneIdx[p][0] ? WORD_W'(rdWord[WORD_W-1:2*LANE_W])
                                                : WORD_W'(rdWord[2*LANE_W-1:0]);
                    rdNow.lanes = LANES_LO_HALF;
                end
                default: begin
                    rdNow.data  = rdWord;
                    rdNow.lanes = mask;
                end
            endcase

            // counter read-back replaces the array word, on all lanes
            if (!pin.chipEnableN && pin.counterReadback) begin
                rdNow.valid = 1'b1;
                rdNow.data  = WORD_W'(cntVal[p]);
                rdNow.lanes = LANES_ALL;
            end

            // output register stage; a powered-down cycle leaves it empty
            st_nxt.port[p].stage = rdNow;

            // latency select: high takes the stage, low bypasses it
            rdSrc = pin.outputLatencySelect ? st_r.port[p].stage
                                            : rdNow;
            if (rdSrc.valid) begin
                st_nxt.port[p].dataOut = rdSrc.data;
            end
            st_nxt.port[p].dataOe = (rdSrc.valid && !pin.outputEnableN)
                                    ? rdSrc.lanes : LANES_NONE;

            // chip enable high for a cycle powers the port down
            st_nxt.port[p].powerDown = pin.chipEnableN;

            // piece sequence of the narrow widths, full width stays at piece zero
            if (!pin.counterClearN) begin
                st_nxt.port[p].piece = PIECE_FIRST;
            end else if (access) begin
                st_nxt.port[p].piece = (pieceUse[p] == pieceEnd[p])
                                       ? PIECE_FIRST : pieceUse[p] + PIECE_STEP;
            end else begin
                st_nxt.port[p].piece = pieceUse[p];
            end
        end
    end

    // single state register; the array is cleared by reset as well
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs come straight from the state register
    assign leftDataOut    = st_r.port[PORT_LEFT].dataOut;
    assign leftDataOe     = st_r.port[PORT_LEFT].dataOe;
    assign leftPowerDown  = st_r.port[PORT_LEFT].powerDown;
    assign rightDataOut   = st_r.port[PORT_RIGHT].dataOut;
    assign rightDataOe    = st_r.port[PORT_RIGHT].dataOe;
    assign rightPowerDown = st_r.port[PORT_RIGHT].powerDown;

endmodule
`default_nettype wire

/* File: include/dpb_pkg.sv */
// package: constants and carrier types of the dual-port burst memory
`default_nettype none
package dpb_pkg;

    // array organisation
    localparam int WORD_W = 36;
    localparam int ADDR_W = 14;
    localparam int DEPTH  = 16384;
    localparam int LANE_W = 9;
    localparam int LANES  = 4;
    localparam int PORTS  = 2;

    // port indices
    localparam int PORT_LEFT  = 0;
    localparam int PORT_RIGHT = 1;

    // burst counter values
    localparam logic [ADDR_W-1:0] CNT_RESET = 14'h0000;
    localparam logic [ADDR_W-1:0] CNT_STEP  = 14'h0001;

    // piece sequencing for the narrow right-port widths
    localparam logic [1:0] PIECE_FIRST    = 2'h0;
    localparam logic [1:0] PIECE_STEP     = 2'h1;
    localparam logic [1:0] PIECE_LAST_X18 = 2'h1;
    localparam logic [1:0] PIECE_LAST_X9  = 2'h3;

    // lane masks
    localparam logic [LANES-1:0] LANES_NONE    = 4'h0;
    localparam logic [LANES-1:0] LANES_ONE     = 4'h1;
    localparam logic [LANES-1:0] LANES_LO_HALF = 4'h3;
    localparam logic [LANES-1:0] LANES_HI_HALF = 4'hC;
    localparam logic [LANES-1:0] LANES_ALL     = 4'hF;

    // transfer width of a port
    typedef enum logic [1:0] {
        WID_FULL,
        WID_X18,
        WID_X9
    } dpb_width_t;

    // synchronous pins of one port
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              addrStrobeN;
        logic              countAdvanceN;
        logic              counterClearN;
        logic              chipEnableN;
        logic              readWriteN;
        logic              outputEnableN;
        logic              outputLatencySelect;
        logic              counterReadback;
        logic [WORD_W-1:0] dataIn;
    } dpb_pin_t;

    // one read result on its way to the pins
    typedef struct packed {
        logic              valid;
        logic [WORD_W-1:0] data;
        logic [LANES-1:0]  lanes;
    } dpb_rd_t;

    // per-port state
    typedef struct packed {
        dpb_rd_t           stage;
        logic [WORD_W-1:0] dataOut;
        logic [LANES-1:0]  dataOe;
        logic [1:0]        piece;
        logic              powerDown;
    } dpb_port_st_t;

    // whole state of the top module
    typedef struct packed {
        logic [DEPTH-1:0][WORD_W-1:0] mem;
        dpb_port_st_t [PORTS-1:0]     port;
    } dpb_top_st_t;

    // state of one burst counter
    typedef struct packed {
        logic [ADDR_W-1:0] cnt;
    } dpb_ctr_st_t;

endpackage
`default_nettype wire

/* File: verilog/dpb_burst_ctr.sv */
// module: burst address counter of one port
`default_nettype none
`timescale 1ns/100ps
module dpb_burst_ctr
    import dpb_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // address control pins
    input  wire logic [ADDR_W-1:0] extAddr,
    input  wire logic              addrStrobeN,
    input  wire logic              countAdvanceN,
    input  wire logic              counterClearN,
    // high when the next access starts a new word
    input  wire logic              stepEn,
    // counter value and address of this cycle's access
    output logic      [ADDR_W-1:0] cntVal,
    output logic      [ADDR_W-1:0] accAddr
);

    dpb_ctr_st_t st_r;
    dpb_ctr_st_t st_nxt;

    // clear beats strobe and advance; load needs strobe and advance together
    always_comb begin
        st_nxt  = st_r;
        accAddr = st_r.cnt;                               // hold
        if (!counterClearN) begin
            st_nxt.cnt = CNT_RESET;
            accAddr    = CNT_RESET;
        end else if (!addrStrobeN) begin
            accAddr = extAddr;                            // external address taken
            if (!countAdvanceN) begin
                st_nxt.cnt = extAddr;
            end
        end else if (!countAdvanceN) begin
            // external address ignored, counter drives the access
            if (stepEn) begin
                accAddr    = st_r.cnt + CNT_STEP;         // wraps at the top
                st_nxt.cnt = accAddr;
            end
        end
    end

    // counter register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cntVal = st_r.cnt;

endmodule
`default_nettype wire

/* File: verif/dpb_dual_port_ram_asserts.sv */
// checker: port timing of the dual-port burst memory
`timescale 1ns/100ps
`default_nettype none
module dpb_dual_port_ram_asserts
    import dpb_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // left port
    input  wire dpb_pin_t          leftPins,
    input  wire logic [LANES-1:0]  byteLaneSelectsN,
    input  wire logic [WORD_W-1:0] leftDataOut,
    input  wire logic [LANES-1:0]  leftDataOe,
    input  wire logic              leftPowerDown,
    // right port
    input  wire dpb_pin_t          rightPins,
    input  wire logic              widthMatchSelect,
    input  wire logic              narrowSize,
    input  wire logic              bigEndianSelect,
    input  wire logic [WORD_W-1:0] rightDataOut,
    input  wire logic [LANES-1:0]  rightDataOe,
    input  wire logic              rightPowerDown
);
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // control bits strobe..readback sit just above the data field
    wire logic [7:0] lCmd = leftPins[43:36];
    wire logic [7:0] rCmd = rightPins[43:36];
    // steps of a burst, a readback or a pipelined read
    sequence s_lrb;
        lCmd == 8'hE9;
    endsequence
    sequence s_lload;
        lCmd[7:5] == 3'b001;
    endsequence
    sequence s_rpipe;
        rCmd[4:0] == 5'b01010 && !widthMatchSelect;
    endsequence
    property p_pd;
        rCmd[4] && !rCmd[1] |=> rightPowerDown && rightDataOe == LANES_NONE;
    endproperty
    a_pd: assert property (p_pd) else $error("no power down after chip enable high");
    property p_wake;
        rCmd[4] ##1 s_rpipe |=> rightDataOe == LANES_NONE;
    endproperty
    a_wake: assert property (p_wake) else $error("output woke without an enabled cycle");
    property p_pipe;
        s_rpipe ##1 (!rCmd[4] && rCmd[2:1] == 2'b01) |=> rightDataOe == LANES_ALL;
    endproperty
    a_pipe: assert property (p_pipe) else $error("pipelined read not driven one stage later");
    property p_flow;
        rCmd[4:0] == 5'b01000 && !widthMatchSelect |=> rightDataOe == LANES_ALL;
    endproperty
    a_flow: assert property (p_flow) else $error("flow-through read not driven next cycle");
    property p_lanes;
        lCmd[4:0] == 5'b01000 |=> leftDataOe == ~$past(byteLaneSelectsN);
    endproperty
    a_lanes: assert property (p_lanes) else $error("left drivers differ from selected lanes");
    property p_load;
        s_lload ##1 s_lrb |=> leftDataOut == {22'h0, $past(leftPins.addr, 2)};
    endproperty
    a_load: assert property (p_load) else $error("counter not loaded from address");
    property p_step;
        s_lload ##1 lCmd[7:5] == 3'b101 ##1 s_lrb |=> leftDataOut == {22'h0, $past(leftPins.addr, 3) + CNT_STEP};
    endproperty
    a_step: assert property (p_step) else $error("counter did not step by one");
    property p_clear;
        !lCmd[5] ##1 s_lrb |=> leftDataOut == 36'h000000000;
    endproperty
    a_clear: assert property (p_clear) else $error("counter not zero after clear");
    property p_hold;
        s_lrb ##1 s_lrb |=> $stable(leftDataOut);
    endproperty
    a_hold: assert property (p_hold) else $error("idle counter changed");
endmodule
bind dpb_dual_port_ram dpb_dual_port_ram_asserts chk (
    .ref_clk, .rst_n, .leftPins, .byteLaneSelectsN, .leftDataOut, .leftDataOe, .leftPowerDown,
    .rightPins, .widthMatchSelect, .narrowSize, .bigEndianSelect, .rightDataOut, .rightDataOe, .rightPowerDown
);
`default_nettype wire

/* File: verif/dpb_bus_masters.sv */
// partner: bus masters standing at both ports of the memory
`timescale 1ns/100ps
`default_nettype none
module dpb_bus_masters
    import dpb_pkg::*;
(
    // clock
    input  wire logic             ref_clk,
    // pins toward the memory
    output var  dpb_pin_t         leftPins,
    output var  dpb_pin_t         rightPins,
    output var  logic [LANES-1:0] byteLaneSelectsN,
    output var  logic [2:0]       sideSel
);
    // start idle: chip disabled on both ports
    initial begin
        leftPins = {14'h0000, 8'hFC, 36'h000000000};
        rightPins = {14'h0000, 8'hFC, 36'h000000000};
        byteLaneSelectsN = 4'h0;
        sideSel = 3'h0;
    end
    // data lines not written are released, so show the inverse rather than a stale word
    function automatic dpb_pin_t held(input dpb_pin_t p, input dpb_pin_t last);
        held = p;
        if (p.readWriteN) begin
            held.dataIn = ~last.dataIn;
        end
    endfunction
    // one cycle on both ports; latency select and strobes stand the whole cycle
    task automatic step(input dpb_pin_t l, input dpb_pin_t r, input logic [LANES-1:0] lanesN, input logic [2:0] side);
        @(posedge ref_clk);
        leftPins <= held(l, leftPins);
        rightPins <= held(r, rightPins);
        byteLaneSelectsN <= lanesN;
        sideSel <= side;
        #1;
    endtask
endmodule
`default_nettype wire

/* File: verif/dpb_dual_port_ram_tb.sv */
// testbench: port scenarios of the dual-port burst memory
`timescale 1ns/100ps
`default_nettype none
module dpb_dual_port_ram_tb
    import dpb_pkg::*;
;
    // control bytes, strobe first; low active except pipe select and readback
    localparam logic [7:0]        C_RD   = 8'h68;
    localparam logic [7:0]        C_WR   = 8'h64;
    localparam logic [7:0]        C_PRD  = 8'h6A;
    localparam logic [7:0]        C_LDW  = 8'h24;
    localparam logic [7:0]        C_ADVW = 8'hA4;
    localparam logic [7:0]        C_LDR  = 8'h2C;
    localparam logic [7:0]        C_ADVR = 8'hAC;
    localparam logic [7:0]        C_RB   = 8'hE9;
    localparam logic [7:0]        C_CLR  = 8'h0C;
    localparam logic [WORD_W-1:0] D1     = 36'h987654321;
    localparam logic [WORD_W-1:0] D2     = 36'hA5A5A5A5A;
    localparam dpb_pin_t          IDLE_P = {14'h0000, 8'hFC, 36'h000000000};
    logic                         ref_clk;
    logic                         rst_n;
    dpb_pin_t                     leftPins;
    dpb_pin_t                     rightPins;
    logic [LANES-1:0]             byteLaneSelectsN;
    logic [2:0]                   sideSel;
    logic [WORD_W-1:0]            leftDataOut;
    logic [WORD_W-1:0]            rightDataOut;
    logic [LANES-1:0]             leftDataOe;
    logic [LANES-1:0]             rightDataOe;
    logic                         leftPowerDown;
    logic                         rightPowerDown;
    int                           mismatches = 0;
    int                           comparisons = 0;
    int                           cycles = 0;
    // far side and device
    dpb_bus_masters mst (.ref_clk, .leftPins, .rightPins, .byteLaneSelectsN, .sideSel);
    dpb_dual_port_ram uut (
        .ref_clk, .rst_n, .leftPins, .byteLaneSelectsN, .leftDataOut, .leftDataOe, .leftPowerDown, .rightPins,
        .widthMatchSelect(sideSel[2]), .narrowSize(sideSel[1]), .bigEndianSelect(sideSel[0]),
        .rightDataOut, .rightDataOe, .rightPowerDown
    );
    function automatic dpb_pin_t pin(input logic [ADDR_W-1:0] a, input logic [7:0] c, input logic [WORD_W-1:0] d);
        pin = {a, c, d};
    endfunction
    task automatic st(input dpb_pin_t l, input dpb_pin_t r);
        mst.step(l, r, LANES_NONE, 3'h0);
    endtask
    task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // both ports write, then read each other's word
    task automatic t_rw();
        st(pin(14'h0123, C_WR, D1), pin(14'h0456, C_WR, D2));
        st(pin(14'h0456, C_RD, 36'h0), pin(14'h0123, C_RD, 36'h0));
        st(IDLE_P, IDLE_P);
        check(leftDataOut, D2);
        check(rightDataOut, D1);
        check(rightDataOe, LANES_ALL);
    endtask
    // disabled cycle, then pipelined reads: first slot stays dark
    task automatic t_pipe();
        st(IDLE_P, IDLE_P);
        st(IDLE_P, pin(14'h0123, C_PRD, 36'h0));
        check(rightPowerDown, 1'b1);
        check(leftPowerDown, 1'b1);
        st(IDLE_P, pin(14'h0123, C_PRD, 36'h0));
        check(rightDataOe, LANES_NONE);
        check(rightPowerDown, 1'b0);
        st(IDLE_P, pin(14'h0123, C_PRD, 36'h0));
        check(rightDataOut, D1);
        check(rightDataOe, LANES_ALL);
    endtask
    // left write burst across the top of the array; right counter untouched
    task automatic t_burst();
        logic [WORD_W-1:0] exp [3];
        exp = '{D2, D1, ~D1};
        st(pin(14'h3FFE, C_LDW, D2), pin(14'h0000, C_RB, 36'h0));
        st(pin(14'h0000, C_ADVW, D1), IDLE_P);
        check(rightDataOut, 36'h0);
        st(pin(14'h0000, C_ADVW, ~D1), IDLE_P);
        for (int i = 0; i < 4; i++) begin
            st(IDLE_P, (i < 3) ? pin(ADDR_W'(14'h3FFE + i), C_RD, 36'h0) : IDLE_P);
            if (i > 0) begin
                check(rightDataOut, exp[i-1]);
            end
        end
    endtask
    // counter load, step, hold, clear over strobe, readback
    task automatic t_count();
        st(pin(14'h1234, C_LDR, 36'h0), IDLE_P);
        st(pin(14'h0000, C_ADVR, 36'h0), IDLE_P);
        st(pin(14'h0000, C_RB, 36'h0), IDLE_P);
        st(pin(14'h0000, C_RB, 36'h0), IDLE_P);
        check(leftDataOut, 36'h000001235);
        st(pin(14'h3333, C_CLR, 36'h0), IDLE_P);
        check(leftDataOut, 36'h000001235);
        st(pin(14'h0000, C_RB, 36'h0), IDLE_P);
        st(pin(14'h0ABC, C_LDR, 36'h0), IDLE_P);
        check(leftDataOut, 36'h0);
        st(pin(14'h0000, C_RB, 36'h0), IDLE_P);
        st(IDLE_P, IDLE_P);
        check(leftDataOut, 36'h000000ABC);
    endtask
    // lanes 1 and 3 only are written and driven
    task automatic t_bytes();
        mst.step(pin(14'h0123, C_WR, 36'hFFFFFFFFF), IDLE_P, 4'h5, 3'h0);
        mst.step(pin(14'h0123, C_RD, 36'h0), IDLE_P, 4'h5, 3'h0);
        st(pin(14'h0123, C_RD, 36'h0), IDLE_P);
        check(leftDataOe, 4'hA);
        st(IDLE_P, IDLE_P);
        check(leftDataOut, D1 | 36'hFF803FE00);
    endtask
    // right port writes one word as two x18 pieces, low piece first
    task automatic t_narrow();
        mst.step(IDLE_P, pin(14'h0200, C_LDW, 36'h00002AAAA), 4'h0, 3'h4);
        mst.step(IDLE_P, pin(14'h0000, C_ADVW, 36'h000015555), 4'h0, 3'h4);
        st(pin(14'h0200, C_RD, 36'h0), IDLE_P);
        st(IDLE_P, IDLE_P);
        check(leftDataOut, {18'h15555, 18'h2AAAA});
    endtask
    // right port writes one word as four x9 pieces, big endian: top lane first
    task automatic t_x9be();
        mst.step(IDLE_P, pin(14'h0300, C_LDW, 36'h000000011), 4'h0, 3'h7);
        mst.step(IDLE_P, pin(14'h0000, C_ADVW, 36'h000000022), 4'h0, 3'h7);
        mst.step(IDLE_P, pin(14'h0000, C_ADVW, 36'h000000033), 4'h0, 3'h7);
        mst.step(IDLE_P, pin(14'h0000, C_ADVW, 36'h000000044), 4'h0, 3'h7);
        st(pin(14'h0300, C_RD, 36'h0), IDLE_P);
        st(IDLE_P, IDLE_P);
        check(leftDataOut, {9'h011, 9'h022, 9'h033, 9'h044});
    endtask
    // clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // cut a hang short; the scenarios need well under a hundred cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 500) begin
            mismatches++;
            final_report();
        end
    end
    // main sequence
    initial begin
        rst_n = 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_rw();
        t_pipe();
        t_burst();
        t_count();
        t_bytes();
        t_narrow();
        t_x9be();
        final_report();
    end
endmodule
`default_nettype wire
